// ### verilog/fcd_ctrl.sv
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - mass erase command code starts erase
// - core stalls during erase, clock runs
// - status shows erase progress, debugger polls
// - relock automatically after mass erase
// - bypass routes flash signals to pins
// - bypass supports page erase too
// - debug ignores write protect option
// - debug ignores sector protection
// - debug programs anywhere in array
// - debug sector bits clearable and settable
// - debug unlock needs no second page write
// - debug page select writable while unlocked
// - mass erase allowed only in debug
// - single open page per unlock in normal mode; debug stays unlocked after a request
module fcd_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic cpu_stall,
  output logic fl_prog,
  output logic fl_erase,
  output logic fl_mass,
  output logic [14:0] fl_addr,
  output logic [7:0] fl_data,
  input wire logic byp_prog,
  input wire logic byp_erase,
  input wire logic [14:0] byp_addr,
  input wire logic [7:0] byp_data
);
  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  logic wr_q;
  logic [7:0] wa_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  function automatic logic wr_at(input logic [7:0] a, input logic v, input logic [7:0] w);
    wr_at = v && (a == w);
  endfunction

  logic w_ctrl;
  logic w_page;
  logic w_sect;
  logic w_mode;
  logic w_req;
  assign w_ctrl = wr_at(wa_q, wr_q, fcd_pkg::ADDR_CTRL);
  assign w_page = wr_at(wa_q, wr_q, fcd_pkg::ADDR_PAGE);
  assign w_sect = wr_at(wa_q, wr_q, fcd_pkg::ADDR_SECT);
  assign w_mode = wr_at(wa_q, wr_q, fcd_pkg::ADDR_MODE);
  assign w_req = wr_at(wa_q, wr_q, fcd_pkg::ADDR_REQ);

  // ----------------------------------------
  // mode register
  // ----------------------------------------
  logic [2:0] mode_q;
  logic dbg;
  logic byp;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= 3'h0;
    end else if (w_mode) begin
      mode_q <= hwdata[2:0];
    end
  end
  assign dbg = mode_q[fcd_pkg::MODE_DBG];
  assign byp = mode_q[fcd_pkg::MODE_BYP];

  // ----------------------------------------
  // unlock state machine
  // ----------------------------------------
  fcd_pkg::fcd_state_t st_q;
  logic [7:0] page_q;
  logic [7:0] sect_q;
  logic [12:0] cnt_q;
  logic done_q;
  logic deny_q;
  logic page_ok;
  logic req_fire;
  localparam logic [12:0] MASS_N = 13'(fcd_pkg::MASS_CYC - 1);
  // normal mode: page write only while locked or half-open; debug: any time except during mass erase
  assign page_ok = dbg || st_q != fcd_pkg::ST_OPEN;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_q <= fcd_pkg::PAGE_RST;
    end else if (w_page && page_ok && st_q != fcd_pkg::ST_MASS) begin
      page_q <= hwdata[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sect_q <= fcd_pkg::SECT_RST;
    end else if (w_sect) begin
      // normal writes only set bits; debug may clear them
      sect_q <= dbg ? hwdata[7:0] : (sect_q | hwdata[7:0]);
    end
  end

  logic unlk1_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= fcd_pkg::ST_LOCKED;
      cnt_q <= 13'h0000;
      unlk1_q <= 1'b0;
    end else begin
      case (st_q)
        fcd_pkg::ST_LOCKED: begin
          if (w_ctrl && hwdata[7:0] == fcd_pkg::CMD_UNLOCK1) begin
            unlk1_q <= 1'b1;
          end else if (w_ctrl && unlk1_q && hwdata[7:0] == fcd_pkg::CMD_UNLOCK2) begin
            unlk1_q <= 1'b0;
            // debug skips the repeated page write
            st_q <= dbg ? fcd_pkg::ST_OPEN : fcd_pkg::ST_HALF;
          end else if (w_ctrl) begin
            unlk1_q <= 1'b0;
          end
        end
        fcd_pkg::ST_HALF: begin
          if (w_page) begin
            st_q <= (hwdata[7:0] == page_q) ? fcd_pkg::ST_OPEN : fcd_pkg::ST_LOCKED;
          end else if (w_ctrl) begin
            st_q <= fcd_pkg::ST_LOCKED;
          end
        end
        fcd_pkg::ST_OPEN: begin
          if (w_ctrl && hwdata[7:0] == fcd_pkg::CMD_MASS && dbg) begin
            st_q <= fcd_pkg::ST_MASS;
            cnt_q <= MASS_N;
          end else if (w_ctrl) begin
            st_q <= fcd_pkg::ST_LOCKED;
          end else if (req_fire && !dbg) begin
            // one page per unlock: relock after each operation
            st_q <= fcd_pkg::ST_LOCKED;
          end
        end
        fcd_pkg::ST_MASS: begin
          if (cnt_q == 13'h0000) begin
            st_q <= fcd_pkg::ST_LOCKED;
          end else begin
            cnt_q <= cnt_q - 13'h0001;
          end
        end
        default: st_q <= fcd_pkg::ST_LOCKED;
      endcase
    end
  end

  // ----------------------------------------
  // program / erase requests
  // ----------------------------------------
  logic allow;
  assign req_fire = w_req && hwdata[fcd_pkg::REQ_GO] && st_q == fcd_pkg::ST_OPEN;
  fcd_guard u_guard (
    .debug(dbg),
    .wp_opt(mode_q[fcd_pkg::MODE_WP]),
    .sect_prot(sect_q),
    .page_sel(page_q),
    .addr(hwdata[14:0]),
    .allow(allow)
  );
  logic prog_q;
  logic erase_q;
  logic [14:0] addr_q;
  logic [7:0] data_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_q <= 1'b0;
      erase_q <= 1'b0;
      addr_q <= 15'h0000;
      data_q <= 8'h00;
      deny_q <= 1'b0;
    end else begin
      prog_q <= 1'b0;
      erase_q <= 1'b0;
      if (req_fire && allow) begin
        prog_q <= !hwdata[fcd_pkg::REQ_ERASE];
        erase_q <= hwdata[fcd_pkg::REQ_ERASE];
        addr_q <= hwdata[14:0];
        data_q <= hwdata[31:24];
        deny_q <= 1'b0;
      end else if (req_fire) begin
        deny_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (st_q == fcd_pkg::ST_MASS && cnt_q == 13'h0000) begin
      done_q <= 1'b1;
    end else if (st_q == fcd_pkg::ST_MASS) begin
      done_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // flash outputs and bypass mux
  // ----------------------------------------
  // bypass hands prog, erase, address and data pins straight to the flash array; fl_mass and cpu_stall stay with the controller
  assign fl_prog = byp ? byp_prog : prog_q;
  assign fl_erase = byp ? byp_erase : erase_q;
  assign fl_addr = byp ? byp_addr : addr_q;
  assign fl_data = byp ? byp_data : data_q;
  assign fl_mass = (st_q == fcd_pkg::ST_MASS);
  assign cpu_stall = (st_q == fcd_pkg::ST_MASS);

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic rd_q;
  logic [7:0] ra_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      ra_q <= 8'h00;
    end else if (hready) begin
      rd_q <= hsel && htrans[1] && !hwrite;
      ra_q <= haddr[7:0];
    end
  end
  logic [31:0] stat_w;
  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[fcd_pkg::STAT_BUSY] = (st_q == fcd_pkg::ST_MASS);
    stat_w[fcd_pkg::STAT_UNLK] = (st_q == fcd_pkg::ST_OPEN);
    stat_w[fcd_pkg::STAT_DONE] = done_q;
    stat_w[fcd_pkg::STAT_DENY] = deny_q;
  end
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_q) begin
      case (ra_q)
        fcd_pkg::ADDR_CTRL: hrdata = {30'h0, st_q};
        fcd_pkg::ADDR_STAT: hrdata = stat_w;
        fcd_pkg::ADDR_PAGE: hrdata = {24'h0, page_q};
        fcd_pkg::ADDR_SECT: hrdata = {24'h0, sect_q};
        fcd_pkg::ADDR_MODE: hrdata = {29'h0, mode_q};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_mass_start;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == fcd_pkg::ST_OPEN && w_ctrl && hwdata[7:0] == fcd_pkg::CMD_MASS && dbg)
    |=> fcd_pkg::ST_MASS == st_q;
  endproperty
  a_mass_start: assert property (p_mass_start) else $error("mass erase not started");
  property p_stall;
    @(posedge hclk) disable iff (!hresetn)
    $rose(cpu_stall) |-> $past(w_ctrl) && $past(dbg) && $past(st_q) == fcd_pkg::ST_OPEN;
  endproperty
  a_stall: assert property (p_stall) else $error("stall mismatch");
  property p_relock;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == fcd_pkg::ST_MASS && cnt_q == 13'h0000) |=> st_q == fcd_pkg::ST_LOCKED && done_q;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock after erase");
  property p_busy;
    @(posedge hclk) disable iff (!hresetn) $rose(fl_mass) |-> stat_w[0] [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");
  property p_nodbg_mass;
    @(posedge hclk) disable iff (!hresetn) !dbg |=> !$rose(fl_mass);
  endproperty
  a_nodbg_mass: assert property (p_nodbg_mass) else $error("mass erase outside debug");
  property p_byp;
    @(posedge hclk) disable iff (!hresetn) byp |-> fl_erase == byp_erase && fl_prog == byp_prog;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass not routed");
  property p_dbg_unlock;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == fcd_pkg::ST_LOCKED && unlk1_q && dbg && w_ctrl && hwdata[7:0] == fcd_pkg::CMD_UNLOCK2)
    |=> st_q == fcd_pkg::ST_OPEN;
  endproperty
  a_dbg_unlock: assert property (p_dbg_unlock) else $error("debug unlock incomplete");
  property p_one_page;
    @(posedge hclk) disable iff (!hresetn) (req_fire && !dbg) |=> st_q == fcd_pkg::ST_LOCKED;
  endproperty
  a_one_page: assert property (p_one_page) else $error("page left open");
  property p_deny;
    @(posedge hclk) disable iff (!hresetn) (req_fire && !allow) |=> deny_q && !prog_q && !erase_q;
  endproperty
  a_deny: assert property (p_deny) else $error("protected op allowed");
  property p_mass_load;
    @(posedge hclk) disable iff (!hresetn) $rose(fl_mass) |-> cnt_q == MASS_N;
  endproperty
  a_mass_load: assert property (p_mass_load) else $error("erase time not loaded");
  property p_stall_hold;
    @(posedge hclk) disable iff (!hresetn) (cpu_stall && cnt_q != 13'h0000) |=> cpu_stall;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall dropped early");
  property p_done_flag;
    @(posedge hclk) disable iff (!hresetn)
    $fell(fl_mass) |-> stat_w[fcd_pkg::STAT_DONE] && !stat_w[fcd_pkg::STAT_BUSY];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("erase end not reported");
  property p_lock_cmd;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == fcd_pkg::ST_OPEN && w_ctrl && !(hwdata[7:0] == fcd_pkg::CMD_MASS && dbg))
    |=> st_q == fcd_pkg::ST_LOCKED;
  endproperty
  a_lock_cmd: assert property (p_lock_cmd) else $error("command did not relock");
  property p_dbg_stay;
    @(posedge hclk) disable iff (!hresetn) (req_fire && dbg) |=> st_q == fcd_pkg::ST_OPEN;
  endproperty
  a_dbg_stay: assert property (p_dbg_stay) else $error("debug request relocked");
  property p_one_strobe;
    @(posedge hclk) disable iff (!hresetn) (req_fire && allow) |=> prog_q != erase_q;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("strobe missing or doubled");
  property p_sect_norm;
    @(posedge hclk) disable iff (!hresetn)
    (w_sect && !dbg) |=> (sect_q & $past(sect_q)) == $past(sect_q);
  endproperty
  a_sect_norm: assert property (p_sect_norm) else $error("sector bit cleared");
  property p_sect_dbg;
    @(posedge hclk) disable iff (!hresetn) (w_sect && dbg) |=> sect_q == $past(hwdata[7:0]);
  endproperty
  a_sect_dbg: assert property (p_sect_dbg) else $error("debug sector write lost");
  property p_page_dbg;
    @(posedge hclk) disable iff (!hresetn)
    (w_page && dbg && st_q == fcd_pkg::ST_OPEN) |=> page_q == $past(hwdata[7:0]);
  endproperty
  a_page_dbg: assert property (p_page_dbg) else $error("debug page write lost");
  c_mass: cover property (@(posedge hclk) disable iff (!hresetn) $fell(fl_mass));
  c_byp: cover property (@(posedge hclk) disable iff (!hresetn) byp && byp_erase);
  c_prog: cover property (@(posedge hclk) disable iff (!hresetn) prog_q);
endmodule

// ### verilog/fcd_pkg.sv
package fcd_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_PAGE = 8'h08;
  localparam logic [7:0] ADDR_SECT = 8'h0C;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_REQ = 8'h14;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8C;
  localparam logic [7:0] CMD_MASS = 8'h63;
  localparam logic [7:0] CMD_LOCK = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int STAT_BUSY = 0;
  localparam int STAT_UNLK = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_DENY = 3;
  localparam int MODE_DBG = 0;
  localparam int MODE_BYP = 1;
  localparam int MODE_WP = 2;
  localparam int REQ_ERASE = 15;
  localparam int REQ_GO = 16;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] SECT_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam int MASS_TIME_US = 100;
  localparam int CLK_MHZ = 40;
  localparam int MASS_CYC = MASS_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    ST_LOCKED = 2'b00,
    ST_HALF = 2'b01,
    ST_OPEN = 2'b10,
    ST_MASS = 2'b11
  } fcd_state_t;
endpackage

// ### verilog/fcd_guard.sv
`timescale 1ns/1ps
module fcd_guard (
  input wire logic debug,
  input wire logic wp_opt,
  input wire logic [7:0] sect_prot,
  input wire logic [7:0] page_sel,
  input wire logic [14:0] addr,
  output logic allow
);
  // ----------------------------------------
  // protection check for one request
  // ----------------------------------------
  logic sect_hit;
  logic page_ok;
  assign sect_hit = sect_prot[addr[14:12]];
  assign page_ok = (addr[14:7] == page_sel);
  // debug skips option, sectors and page limit
  assign allow = debug | (!wp_opt && !sect_hit && page_ok);
endmodule

// ### tb/fcd_flash_mon.sv
`timescale 1ns/1ps
// ------------------------------
// flash array side, counts strobes
// ------------------------------
module fcd_flash_mon (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fl_prog,
  input wire logic fl_erase,
  input wire logic fl_mass,
  input wire logic [14:0] fl_addr,
  input wire logic [7:0] fl_data,
  output logic [7:0] n_prog,
  output logic [7:0] n_erase,
  output logic [15:0] n_mass,
  output logic [22:0] last
);
  // strobes are counted per cycle high, so a stuck strobe shows as extra counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_prog <= 8'h00;
      n_erase <= 8'h00;
      n_mass <= 16'h0000;
      last <= 23'h000000;
    end else begin
      if (fl_prog) begin
        n_prog <= n_prog + 8'h01;
        last <= {fl_addr, fl_data};
      end
      if (fl_erase) begin
        n_erase <= n_erase + 8'h01;
      end
      if (fl_mass) begin
        n_mass <= n_mass + 16'h0001;
      end
    end
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h00000000;
  logic byp_prog = 1'b0;
  logic byp_erase = 1'b0;
  logic [14:0] byp_addr = 15'h0000;
  logic [7:0] byp_data = 8'h00;
  logic [31:0] hrdata, rdv;
  logic hreadyout, hresp, cpu_stall, fl_prog, fl_erase, fl_mass;
  logic [14:0] fl_addr;
  logic [7:0] fl_data, n_prog, n_erase, ep = 8'h00, ee = 8'h00;
  logic [15:0] n_mass;
  logic [22:0] last, el = 23'h000000;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #12.5 hclk = ~hclk;
  fcd_ctrl fcd_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_stall(cpu_stall),
    .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_mass(fl_mass), .fl_addr(fl_addr),
    .fl_data(fl_data), .byp_prog(byp_prog), .byp_erase(byp_erase), .byp_addr(byp_addr),
    .byp_data(byp_data));
  fcd_flash_mon fcd_flash_mon_i (.hclk(hclk), .hresetn(hresetn), .fl_prog(fl_prog),
    .fl_erase(fl_erase), .fl_mass(fl_mass), .fl_addr(fl_addr), .fl_data(fl_data),
    .n_prog(n_prog), .n_erase(n_erase), .n_mass(n_mass), .last(last));
  // ------------------------------
  // helpers
  // ------------------------------
  task results;
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors = n_errors + 1;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    hsize <= 3'b010;
    // slave outputs read at the edge still hold their pre-edge values
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h00000000);
  endtask
  task stb(input string nm, input int pos, input logic e);
    rd(fcd_pkg::ADDR_STAT);
    chk(nm, {31'h0, e}, {31'h0, rdv[pos]});
  endtask
  task cnt;
    chk("n_prog", {24'h0, ep}, {24'h0, n_prog});
    chk("n_erase", {24'h0, ee}, {24'h0, n_erase});
    chk("last", {9'h0, el}, {9'h0, last});
  endtask
  // normal mode needs the page written before and after the codes
  task open_pg(input logic [7:0] p, input logic nrm);
    if (nrm) wr(fcd_pkg::ADDR_PAGE, {24'h0, p});
    wr(fcd_pkg::ADDR_CTRL, {24'h0, fcd_pkg::CMD_UNLOCK1});
    wr(fcd_pkg::ADDR_CTRL, {24'h0, fcd_pkg::CMD_UNLOCK2});
    if (nrm) wr(fcd_pkg::ADDR_PAGE, {24'h0, p});
  endtask
  task req(input logic [14:0] a, input logic e, input logic [7:0] d);
    wr(fcd_pkg::ADDR_REQ, {d, 7'h00, 1'b1, e, a});
    repeat (3) @(posedge hclk);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task t_normal;
    rd(fcd_pkg::ADDR_STAT);
    chk("stat_rst", 32'h00000000, rdv);
    chk("hresp", 32'h0, {31'h0, hresp});
    wr(fcd_pkg::ADDR_MODE, 32'h00000000);
    open_pg(8'h05, 1'b1);
    req(15'h0291, 1'b0, 8'hA5);
    ep = ep + 8'h01;
    el = {15'h0291, 8'hA5};
    cnt;
    stb("unlk", fcd_pkg::STAT_UNLK, 1'b0);
    req(15'h0291, 1'b0, 8'h11);
    cnt;
    open_pg(8'h05, 1'b1);
    req(15'h0311, 1'b0, 8'h22);
    cnt;
    stb("deny", fcd_pkg::STAT_DENY, 1'b1);
    wr(fcd_pkg::ADDR_MODE, 32'h00000004);
    open_pg(8'h05, 1'b1);
    req(15'h0291, 1'b0, 8'h33);
    cnt;
    wr(fcd_pkg::ADDR_MODE, 32'h00000000);
    wr(fcd_pkg::ADDR_SECT, 32'h00000001);
    wr(fcd_pkg::ADDR_SECT, 32'h00000000);
    rd(fcd_pkg::ADDR_SECT);
    chk("sect_norm", 32'h00000001, rdv);
    open_pg(8'h05, 1'b1);
    req(15'h0291, 1'b0, 8'h44);
    cnt;
  endtask
  task t_debug;
    wr(fcd_pkg::ADDR_MODE, 32'h00000005);
    open_pg(8'h05, 1'b0);
    stb("dbg_unlk", fcd_pkg::STAT_UNLK, 1'b1);
    req(15'h0010, 1'b0, 8'h3C);
    ep = ep + 8'h01;
    el = {15'h0010, 8'h3C};
    cnt;
    req(15'h0080, 1'b1, 8'h00);
    ee = ee + 8'h01;
    cnt;
    wr(fcd_pkg::ADDR_PAGE, 32'h00000022);
    rd(fcd_pkg::ADDR_PAGE);
    chk("page_dbg", 32'h00000022, rdv);
    wr(fcd_pkg::ADDR_SECT, 32'h00000000);
    rd(fcd_pkg::ADDR_SECT);
    chk("sect_clr", 32'h00000000, rdv);
    wr(fcd_pkg::ADDR_SECT, 32'h000000F0);
    rd(fcd_pkg::ADDR_SECT);
    chk("sect_set", 32'h000000F0, rdv);
    wr(fcd_pkg::ADDR_SECT, 32'h00000000);
    wr(fcd_pkg::ADDR_CTRL, {24'h0, fcd_pkg::CMD_LOCK});
  endtask
  task t_mass;
    int i;
    wr(fcd_pkg::ADDR_MODE, 32'h00000000);
    open_pg(8'h05, 1'b1);
    wr(fcd_pkg::ADDR_CTRL, {24'h0, fcd_pkg::CMD_MASS});
    chk("mass_norm", 32'h0, {16'h0, n_mass});
    stb("relock", fcd_pkg::STAT_UNLK, 1'b0);
    wr(fcd_pkg::ADDR_MODE, 32'h00000001);
    open_pg(8'h05, 1'b0);
    wr(fcd_pkg::ADDR_CTRL, {24'h0, fcd_pkg::CMD_MASS});
    @(posedge hclk);
    chk("stall", 32'h1, {31'h0, cpu_stall});
    stb("busy", fcd_pkg::STAT_BUSY, 1'b1);
    i = 0;
    while (rdv[fcd_pkg::STAT_BUSY] !== 1'b0 && i < 6000) begin
      rd(fcd_pkg::ADDR_STAT);
      i = i + 1;
    end
    chk("mass_len", fcd_pkg::MASS_CYC, {16'h0, n_mass});
    chk("done", 32'h1, {31'h0, rdv[fcd_pkg::STAT_DONE]});
    chk("mass_lock", 32'h0, {31'h0, rdv[fcd_pkg::STAT_UNLK]});
    chk("unstall", 32'h0, {31'h0, cpu_stall});
    req(15'h0010, 1'b0, 8'h77);
    cnt;
  endtask
  task t_bypass;
    wr(fcd_pkg::ADDR_MODE, 32'h00000002);
    byp_prog <= 1'b1;
    byp_addr <= 15'h1234;
    byp_data <= 8'h5A;
    @(posedge hclk);
    chk("byp_prog", 32'h1, {31'h0, fl_prog});
    chk("byp_addr", 32'h1234, {17'h0, fl_addr});
    byp_prog <= 1'b0;
    byp_erase <= 1'b1;
    @(posedge hclk);
    chk("byp_erase", 32'h1, {31'h0, fl_erase});
    byp_erase <= 1'b0;
    @(posedge hclk);
    ep = ep + 8'h01;
    ee = ee + 8'h01;
    el = {15'h1234, 8'h5A};
    cnt;
    wr(fcd_pkg::ADDR_MODE, 32'h00000000);
    byp_prog <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("byp_off", 32'h0, {31'h0, fl_prog});
    byp_prog <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_normal;
    t_debug;
    t_mass;
    t_bypass;
    results;
  end
endmodule
